/* inc/frwd_defines.svh */
// constants for the flash rom window decode block
// Operation
// R1 - three system address regions all select the same flash rom device
// R2 - boot regions pass reads only; writes through them are never forwarded
// R3 - after power-on both boot regions, low and high, are enabled
// R4 - after initialization software disables both boot regions
// R5 - programming region reaches flash only when byte mode is enabled
// R6 - processor uses only single-byte loads and stores in programming region
// R7 - control bits disable boot regions, enable byte mode; reset boot on, byte off
`ifndef FRWD_DEFINES_SVH
`define FRWD_DEFINES_SVH
`define FRWD_LOW_BASE 40'h00_0000_0000
`define FRWD_LOW_TOP 40'h00_00ff_ffff
`define FRWD_HIGH_BASE 40'h0f_fc00_0000
`define FRWD_HIGH_TOP 40'h0f_ffff_ffff
`define FRWD_PROG_BASE 40'h87_c000_0000
`define FRWD_PROG_TOP 40'h87_ffff_ffff
`define FRWD_BOOT_EN_RST 1'b1
`define FRWD_BYTE_EN_RST 1'b0
`define FRWD_SIZE_BYTE 2'h0
`endif

/* inc/frwd_pkg.sv */
// types for the flash rom window decode block
package frwd_pkg;
  typedef enum logic [1:0] {
    FRWD_REG_NONE = 2'b00,
    FRWD_REG_LOW = 2'b01,
    FRWD_REG_HIGH = 2'b10,
    FRWD_REG_PROG = 2'b11
  } frwd_region_t;
  typedef logic [39:0] frwd_addr_t;
endpackage

/* src/frwd_region_match.sv */
// address range comparator for one flash window
`timescale 1ns/10ps
module frwd_region_match
  import frwd_pkg::*;
(
  input wire frwd_addr_t addr_i, // system address
  input wire frwd_addr_t base_i, // lowest address of window
  input wire frwd_addr_t top_i,  // highest address of window
  output logic hit_o             // address lies inside
);
  assign hit_o = (addr_i >= base_i) && (addr_i <= top_i);
endmodule

/* src/frwd_top.sv */
// flash rom window decode and access policy
`timescale 1ns/10ps
`include "frwd_defines.svh"
module frwd_top
  import frwd_pkg::*;
(
  input wire logic clk_i,            // 25 mhz system clock
  input wire logic resetn_i,         // async reset, active low
  input wire logic req_i,            // system bus access request, one cycle
  input wire logic we_i,             // 1 write, 0 read
  input wire frwd_addr_t addr_i,     // system byte address
  input wire logic [1:0] size_i,     // 0 byte, other sizes wider
  input wire logic [7:0] wdata_i,    // store byte
  input wire logic boot_dis_set_i,   // pulse: disable boot windows
  input wire logic byte_en_set_i,    // pulse: enable byte mode
  input wire logic byte_en_clr_i,    // pulse: disable byte mode
  input wire logic [7:0] flash_rdata_i, // flash read data, same clock
  output logic flash_cs_o,           // flash select pulse
  output logic flash_we_o,           // flash write strobe
  output logic [23:0] flash_addr_o,  // flash byte address
  output logic [7:0] flash_wdata_o,  // flash write data
  output logic ack_o,                // access accepted by flash
  output logic err_o,                // access refused
  output logic [7:0] rdata_o,        // read data to bus
  output logic boot_en_o,            // boot windows live
  output logic byte_en_o             // byte mode live
);
  // =====================================================
  // control bits
  logic boot_en_r;
  logic byte_en_r;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      boot_en_r <= `FRWD_BOOT_EN_RST; // R3 R7
      byte_en_r <= `FRWD_BYTE_EN_RST; // R7
    end
    else
    begin
      if (boot_dis_set_i)
        boot_en_r <= 1'b0; // R4
      if (byte_en_set_i)
        byte_en_r <= 1'b1; // R7
      else if (byte_en_clr_i)
        byte_en_r <= 1'b0;
    end
  end

  // =====================================================
  // decode
  logic hit_low;
  logic hit_high;
  logic hit_prog;
  frwd_region_match u_low (.addr_i(addr_i), .base_i(`FRWD_LOW_BASE),
    .top_i(`FRWD_LOW_TOP), .hit_o(hit_low)); // R1
  frwd_region_match u_high (.addr_i(addr_i), .base_i(`FRWD_HIGH_BASE),
    .top_i(`FRWD_HIGH_TOP), .hit_o(hit_high)); // R1
  frwd_region_match u_prog (.addr_i(addr_i), .base_i(`FRWD_PROG_BASE),
    .top_i(`FRWD_PROG_TOP), .hit_o(hit_prog)); // R1

  wire boot_hit = boot_en_r && (hit_low || hit_high); // R3 R4
  wire boot_ok = boot_hit && !we_i; // R2
  // wider accesses to the programming window refused outright so they cannot disturb the flash
  wire prog_ok = hit_prog && byte_en_r && (size_i == `FRWD_SIZE_BYTE); // R5 R6
  wire go = req_i && (boot_ok || prog_ok);
  wire refuse = req_i && !go && (boot_hit || hit_prog);
  // boot windows fold onto the whole 16 mbyte of the flash
  wire [23:0] fl_addr = addr_i[23:0]; // R1

  // =====================================================
  // outputs, all registered; read data lags ack by one cycle, flash turnaround of 0
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flash_cs_o <= 1'b0;
      flash_we_o <= 1'b0;
      flash_addr_o <= 24'h000000;
      flash_wdata_o <= 8'h00;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 8'h00;
      boot_en_o <= `FRWD_BOOT_EN_RST;
      byte_en_o <= `FRWD_BYTE_EN_RST;
    end
    else
    begin
      flash_cs_o <= go;
      flash_we_o <= go && we_i; // R2
      if (go)
      begin
        flash_addr_o <= fl_addr;
        flash_wdata_o <= wdata_i;
      end
      ack_o <= go;
      err_o <= refuse;
      if (flash_cs_o && !flash_we_o)
        rdata_o <= flash_rdata_i;
      boot_en_o <= boot_en_r;
      byte_en_o <= byte_en_r;
    end
  end
endmodule

/* verification/frwd_flash_model.sv */
// behavioural flash device answering reads
`timescale 1ns/10ps
module frwd_flash_model
(
  input wire logic cs_i, // flash select
  input wire logic [23:0] addr_i, // flash byte address
  output logic [7:0] rdata_o // read data
);
  // unselected bus shows inverse so stale data never matches
  assign rdata_o = cs_i ? addr_i[7:0] ^ 8'h5a : ~addr_i[7:0];
endmodule

/* verification/frwd_top_assertions.sv */
// checker for flash window decode
`timescale 1ns/10ps
module frwd_chk import frwd_pkg::*;
(
  input wire logic clk_i, resetn_i, req_i, we_i, ack_o, err_o, flash_cs_o, boot_en_o, byte_en_o,
  input wire frwd_addr_t addr_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire lo_w = addr_i < 40'h00_0100_0000;
  wire pg_w = addr_i >= 40'h87_c000_0000 && addr_i <= 40'h87_ffff_ffff;
  property p_rst; $rose(resetn_i) |-> boot_en_o && !byte_en_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_rd; req_i && !we_i && boot_en_o && lo_w |=> ack_o && flash_cs_o; endproperty
  a_rd: assert property (p_rd) else $error("boot read lost");
  property p_wr; req_i && we_i && lo_w |=> !ack_o && !flash_cs_o; endproperty
  a_wr: assert property (p_wr) else $error("boot write passed");
  property p_off; !boot_en_o && req_i && lo_w |=> !ack_o && !flash_cs_o; endproperty
  a_off: assert property (p_off) else $error("disabled boot decoded");
  property p_stk; !boot_en_o |=> !boot_en_o; endproperty
  a_stk: assert property (p_stk) else $error("boot enable came back");
  property p_pg; req_i && !byte_en_o && pg_w |=> err_o && !flash_cs_o; endproperty
  a_pg: assert property (p_pg) else $error("prog access without byte mode");
  c_wr: cover property (ack_o && !boot_en_o);
  c_er: cover property (err_o);
  c_by: cover property (byte_en_o && ack_o);
endmodule
bind frwd_top frwd_chk u_chk (.*);

/* verification/test_frwd_top.sv */
// self-checking bench for flash window decode
`timescale 1ns/10ps
module test_frwd_top;
  import frwd_pkg::*;
  logic clk_i = 0, resetn_i = 0, req_i = 0, we_i = 0, bd = 0, bs = 0, bc = 0, cs, ack, err, ben, yen;
  logic [1:0] size_i = 0, q[$];
  logic [7:0] wd = 0, fr, rd;
  logic [23:0] fa;
  logic [32:0] qf[$];
  logic fwe;
  logic [7:0] fwd;
  frwd_addr_t addr_i = 0;
  int fails = 0, checks_done = 0;
  logic [31:0] lfsr = 32'h9d06610d;
  always #20 clk_i = ~clk_i;
  frwd_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
    .size_i(size_i), .wdata_i(wd), .boot_dis_set_i(bd), .byte_en_set_i(bs), .byte_en_clr_i(bc),
    .flash_rdata_i(fr), .flash_cs_o(cs), .flash_we_o(fwe), .flash_addr_o(fa), .flash_wdata_o(fwd),
    .ack_o(ack), .err_o(err), .rdata_o(rd), .boot_en_o(ben), .byte_en_o(yen));
  frwd_flash_model u_fl (.cs_i(cs), .addr_i(fa), .rdata_o(fr));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [39:0] s, input logic [39:0] e);
    checks_done++;
    if (s !== e) begin fails++; $display("wrong value at %0t: %h expected %h", $time, s, e); end
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task acc(input logic w, input frwd_addr_t a, input logic [1:0] s, input logic [1:0] e);
    @(posedge clk_i);
    #1 {req_i, we_i, addr_i, size_i, wd} = {1'b1, w, a, s, lfsr[7:0]};
    if (e != 0) q.push_back(e);
    if (e == 2'b10) qf.push_back({w, lfsr[7:0], a[23:0]});
    @(posedge clk_i);
    #1 req_i = 0;
  endtask
  task pl(input logic [2:0] k);
    @(posedge clk_i);
    #1 {bd, bs, bc} = k;
    @(posedge clk_i);
    #1 {bd, bs, bc} = 0;
  endtask
  always @(posedge clk_i) #2 if ((ack | err) === 1'b1) chk({ack, err}, q.pop_front());
  always @(posedge clk_i) #2 if (ack === 1'b1) chk({fwe, fwd, fa}, qf.pop_front());
  initial begin
    repeat (8) @(posedge clk_i);
    #1 resetn_i = 1;
    chk({ben, yen}, 2'b10);
    acc(0, 40'h0f_fc00_0010, 0, 2'b10);
    @(posedge clk_i);
    #2 chk(rd, 8'h4a);
    acc(1, 40'h00_00ff_ffff, 0, 2'b01);
    acc(0, 40'h87_c000_0000, 0, 2'b01);
    pl(3'b011);
    repeat (8) begin
      lfsr = lfsr_next(lfsr);
      acc(lfsr[31], {10'h21f, lfsr[29:0]}, lfsr[30] ? 2'h2 : 2'h0, lfsr[30] ? 2'b01 : 2'b10);
    end
    pl(3'b100);
    pl(3'b001);
    acc(0, 40'h00_0000_0040, 0, 2'b00);
    acc(0, 40'h87_ffff_ffff, 0, 2'b01);
    @(posedge clk_i);
    #2 chk({ben, yen, 6'(q.size()), 6'(qf.size())}, 14'h0000);
    close_out;
  end
endmodule
